// [rtl/cfgsp_port.sv]
`timescale 1ns/1ns
`include "cfgsp_regs.svh"
////////////////////////////////////////////////////////////////////////////////
module cfgsp_port
  import cfgsp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic sclk,
  input wire logic serial_in,
  input wire logic chip_select_low,
  output logic serial_out,
  output logic serial_out_oe,
  input wire logic [7:0] status_byte,
  output logic strobe_pulse,
  output logic [5:0] strobe_addr,
  output logic fifo_write,
  output logic fifo_tx_sel,
  output logic [7:0] fifo_wdata,
  input wire logic [7:0] fifo_rdata,
  output logic [33*16-1:0] reg_image
);
  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation
  logic [2:0] pins_s;
  cfgsp_sync u_sync (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .pin_in({sclk, serial_in, chip_select_low}),
    .pin_out(pins_s)
  );
  wire sclk_s = pins_s[2];
  wire si_s = pins_s[1];
  wire cs_n_s = pins_s[0];

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic sclk_d_r;
  cfgsp_phase_t phase_r;
  logic [4:0] cnt_r;
  logic [7:0] hdr_r;
  logic [15:0] sh_in_r;
  logic [15:0] sh_out_r;
  logic out_r;
  logic [15:0] regs_r [`CFGSP_REG_COUNT];

  // Edge and decode terms
  wire rise = sclk_s & ~sclk_d_r & ~cs_n_s;
  wire fall = ~sclk_s & sclk_d_r & ~cs_n_s;
  wire [7:0] hdr_full = {hdr_r[6:0], si_s};
  wire hdr_done = rise && phase_r == CFGSP_HDR && cnt_r == 5'd7;
  wire [5:0] addr_new = hdr_full[5:0];
  wire [5:0] addr_cur = hdr_r[5:0];
  wire is_read = hdr_r[`CFGSP_RW_BIT];
  // Address classes
  wire strobe_hit = addr_new <= `CFGSP_STROBE_LAST;
  wire fifo_hit = addr_new == `CFGSP_FIFO_TX || addr_new == `CFGSP_FIFO_RX;
  wire [5:0] reg_off = addr_new - `CFGSP_REG_FIRST;
  wire reg_hit = addr_new >= `CFGSP_REG_FIRST &&
                 reg_off < 6'(`CFGSP_REG_COUNT);
  wire [5:0] cur_off = addr_cur - `CFGSP_REG_FIRST;
  wire cur_fifo = addr_cur == `CFGSP_FIFO_TX || addr_cur == `CFGSP_FIFO_RX;
  wire [4:0] data_len = cur_fifo ? 5'd7 : 5'd15;
  wire data_done = rise && phase_r == CFGSP_DATA && cnt_r == data_len;
  wire [15:0] rd_word = reg_hit ? regs_r[reg_off[5:0]] :
                        fifo_hit ? {fifo_rdata, 8'h00} : 16'h0000;
  wire is_reg_wr = !is_read && !cur_fifo;
  // Strobe header: another header follows at once
  wire hdr_only = !hdr_full[`CFGSP_RAM_BIT] && strobe_hit;

  ////////////////////////////////////////////////////////////////////////////
  // Phase sequencing; a new header follows each access except a RAM header, which skips until deselect
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sclk_d_r <= 1'b0;
      phase_r <= CFGSP_HDR;
      cnt_r <= 5'd0;
      hdr_r <= 8'h00;
      sh_in_r <= 16'h0000;
    end else begin
      sclk_d_r <= sclk_s;
      if (cs_n_s) begin
        phase_r <= CFGSP_HDR;
        cnt_r <= 5'd0;
      end else if (rise) begin
        cnt_r <= cnt_r + 5'd1;
        case (phase_r)
          CFGSP_HDR: begin
            hdr_r <= hdr_full;
            if (cnt_r == 5'd7) begin
              cnt_r <= 5'd0;
              if (hdr_full[`CFGSP_RAM_BIT])
                phase_r <= CFGSP_SKIP;
              else if (strobe_hit)
                phase_r <= CFGSP_HDR;
              else
                phase_r <= CFGSP_DATA;
            end
          end
          CFGSP_DATA: begin
            sh_in_r <= {sh_in_r[14:0], si_s};
            if (cnt_r == data_len) begin
              cnt_r <= 5'd0;
              phase_r <= CFGSP_HDR;
            end
          end
          default: cnt_r <= 5'd0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file; reset only by arst_n, not by deselect, order free
  genvar gi;
  generate
    for (gi = 0; gi < `CFGSP_REG_COUNT; gi++) begin : g_reg
      always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n)
          regs_r[gi] <= `CFGSP_REG_RESET;
        else if (data_done && is_reg_wr && cur_off == 6'(gi))
          regs_r[gi] <= {sh_in_r[14:0], si_s};
      end
      assign reg_image[gi*16 +: 16] = regs_r[gi];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Strobe and FIFO side outputs
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      strobe_pulse <= 1'b0;
      strobe_addr <= 6'h00;
      fifo_write <= 1'b0;
      fifo_tx_sel <= 1'b0;
      fifo_wdata <= 8'h00;
    end else begin
      strobe_pulse <= hdr_done && !hdr_full[`CFGSP_RAM_BIT] &&
                      !hdr_full[`CFGSP_RW_BIT] && strobe_hit;
      if (hdr_done)
        strobe_addr <= addr_new;
      fifo_write <= data_done && cur_fifo && !is_read;
      if (data_done) begin
        fifo_tx_sel <= addr_cur == `CFGSP_FIFO_TX;
        fifo_wdata <= {sh_in_r[6:0], si_s};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output shifter, advanced on falling edges
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sh_out_r <= 16'h0000;
      out_r <= 1'b0;
    end else if (cs_n_s) begin
      // Bit 7 already stands on the pin; the shifter holds the rest
      sh_out_r <= {status_byte[6:0], 9'h000};
      out_r <= status_byte[7];
    end else if (hdr_done) begin
      if (hdr_only)
        sh_out_r <= {status_byte, 8'h00};
      else
        sh_out_r <= hdr_full[`CFGSP_RW_BIT] ? rd_word : 16'h0000;
    end else if (data_done) begin
      sh_out_r <= {status_byte, 8'h00};
    end else if (fall) begin
      out_r <= sh_out_r[15];
      sh_out_r <= {sh_out_r[14:0], 1'b0};
    end
  end

  // Pin drive
  assign serial_out = out_r;
  assign serial_out_oe = ~cs_n_s;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence hdr_wr_s;
    hdr_done && !hdr_full[7] && !hdr_full[6] && reg_hit;
  endsequence

  oe_release_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    chip_select_low && $past(chip_select_low) && $past(chip_select_low, 2)
    |-> !serial_out_oe)
    else $error("output driven while deselected");
  oe_drive_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !chip_select_low && !$past(chip_select_low) && !$past(chip_select_low, 2)
    |-> serial_out_oe)
    else $error("output released while selected");
  strobe_range_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    strobe_pulse |-> strobe_addr <= 6'h0E) else $error("strobe out of range");
  strobe_no_data_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    strobe_pulse |-> phase_r == CFGSP_HDR && cnt_r == 5'd0)
    else $error("strobe did not return to header");
  hdr_to_data_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    hdr_wr_s |=> phase_r == CFGSP_DATA && cnt_r == 5'd0)
    else $error("register header did not open data phase");
  commit_after_d0_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    data_done && is_reg_wr && cur_off < 6'd33 |=>
    regs_r[$past(cur_off)] == $past({sh_in_r[14:0], si_s}))
    else $error("register not committed at last bit");
  no_early_commit_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !data_done |=> $stable(reg_image))
    else $error("register changed without last bit");
  fall_shift_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !cs_n_s && !hdr_done && !data_done && fall |=>
    serial_out == $past(sh_out_r[15]))
    else $error("output not advanced on falling edge");
  read_load_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    hdr_done && hdr_full[6] && reg_hit |=> sh_out_r == $past(rd_word))
    else $error("read data not loaded");
  next_hdr_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    data_done |=> phase_r == CFGSP_HDR && cnt_r == 5'd0)
    else $error("no new header after access");
endmodule

// [rtl/cfgsp_sync.sv]
`timescale 1ns/1ns
// Two-flop synchroniser for the serial pins
module cfgsp_sync (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [2:0] pin_in,
  output logic [2:0] pin_out
);
  logic [2:0] meta_r;
  logic [2:0] sync_r;
  assign pin_out = sync_r;
  // First stage feeds only the second stage; reset to idle pin levels
  // (clock low, data high, select high) so no false edge follows reset
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_r <= 3'h3;
      sync_r <= 3'h3;
    end else begin
      meta_r <= pin_in;
      sync_r <= meta_r;
    end
  end
endmodule

// [shared/cfgsp_pkg.sv]
package cfgsp_pkg;
  // Transaction phase
  typedef enum logic [1:0] {
    CFGSP_HDR = 2'b00,
    CFGSP_DATA = 2'b01,
    CFGSP_SKIP = 2'b10
  } cfgsp_phase_t;
endpackage

// [shared/cfgsp_regs.svh]
`ifndef CFGSP_REGS_SVH
`define CFGSP_REGS_SVH
// Header layout and address map
`define CFGSP_HDR_BITS 8
`define CFGSP_DATA_BITS 16
`define CFGSP_RAM_BIT 7
`define CFGSP_RW_BIT 6
`define CFGSP_STROBE_LAST 6'h0E
`define CFGSP_FIFO_TX 6'h3E
`define CFGSP_FIFO_RX 6'h3F
`define CFGSP_REG_FIRST 6'h10
`define CFGSP_REG_COUNT 33
`define CFGSP_REG_RESET 16'h0000
`endif

// [testbench/cfgsp_host.sv]
`timescale 1ns/1ns
// Host model: serial master, clock stands low outside frames
module cfgsp_host (
  input wire logic sys_clk,
  input wire logic so_line,
  output logic sclk,
  output logic serial_in,
  output logic chip_select_low
);
  // Idle levels at time zero
  initial begin
    sclk = 1'b0;
    serial_in = 1'b1;
    chip_select_low = 1'b1;
  end
  // Select change with setup and hold margin around it
  task automatic sel(input logic lvl);
    repeat (6) @(negedge sys_clk);
    chip_select_low = lvl;
    repeat (6) @(negedge sys_clk);
  endtask
  // Send top nbits of tx, MSB first; 64 ns per bit, sample late in high
  task automatic xfer(input logic [23:0] tx, input int nbits,
                      output logic [23:0] rx);
    rx = 24'h0000;
    for (int i = 23; i >= 24 - nbits; i--) begin
      serial_in = tx[i];
      repeat (4) @(negedge sys_clk);
      sclk = 1'b1;
      repeat (4) @(negedge sys_clk);
      rx = {rx[22:0], so_line};
      sclk = 1'b0;
    end
  endtask
endmodule

// [testbench/tb_top.sv]
`timescale 1ns/1ns
// Bench for the configuration serial port
module tb_top;
  logic sys_clk, arst_n, sclk, serial_in, chip_select_low;
  logic serial_out, serial_out_oe, strobe_pulse, fifo_write, fifo_tx_sel;
  logic [5:0] strobe_addr, last_strobe;
  logic [7:0] status_byte, fifo_rdata, fifo_wdata, last_fifo;
  logic [33*16-1:0] reg_image;
  logic [23:0] rx, st, fr;
  logic last_sel;
  int mismatches, tests_run, n_strobe;
  wire so_line = serial_out_oe ? serial_out : 1'b1; // Pull-up when released

  cfgsp_port i_dut (.sys_clk(sys_clk), .arst_n(arst_n), .sclk(sclk),
    .serial_in(serial_in), .chip_select_low(chip_select_low),
    .serial_out(serial_out), .serial_out_oe(serial_out_oe),
    .status_byte(status_byte), .strobe_pulse(strobe_pulse),
    .strobe_addr(strobe_addr), .fifo_write(fifo_write),
    .fifo_tx_sel(fifo_tx_sel), .fifo_wdata(fifo_wdata),
    .fifo_rdata(fifo_rdata), .reg_image(reg_image));
  cfgsp_host i_host (.sys_clk(sys_clk), .so_line(so_line), .sclk(sclk),
    .serial_in(serial_in), .chip_select_low(chip_select_low));

  ///////////////////////////////////////////////////////////////////////////
  // Clock
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // Catch one-cycle pulses away from the edge that launches them
  always @(negedge sys_clk) begin
    if (strobe_pulse === 1'b1) begin
      n_strobe++;
      last_strobe = strobe_addr;
    end
    if (fifo_write === 1'b1) begin
      last_fifo = fifo_wdata;
      last_sel = fifo_tx_sel;
    end
  end
  // Compare and count
  task automatic chk(input logic [23:0] got, input logic [23:0] exp,
                     input string m);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t %s", $time, m);
    end
  endtask
  task automatic give_verdict;
    $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Write then read back in one select
  task automatic t_rw;
    i_host.sel(1'b0);
    i_host.xfer({2'b00, 6'h10, 16'hA5C3}, 24, rx);
    i_host.xfer({2'b01, 6'h10, 16'h0000}, 24, rx);
    i_host.sel(1'b1);
    chk(rx, {8'h96, 16'hA5C3}, "read back");
    chk({8'h00, reg_image[15:0]}, 24'h00_A5C3, "reg 0x10");
    chk({23'h0, serial_out_oe}, 24'h0000, "oe idle");
    $display("test rw done");
  endtask
  // Out of order writes and an unmapped read
  task automatic t_order;
    i_host.sel(1'b0);
    i_host.xfer({2'b00, 6'h30, 16'h1234}, 24, rx);
    i_host.xfer({2'b00, 6'h20, 16'hBEEF}, 24, rx);
    i_host.xfer({2'b01, 6'h31, 16'hFFFF}, 24, rx);
    i_host.sel(1'b1);
    chk({8'h00, reg_image[32*16 +: 16]}, 24'h00_1234, "reg 0x30");
    chk({8'h00, reg_image[16*16 +: 16]}, 24'h00_BEEF, "reg 0x20");
    chk({8'h00, rx[15:0]}, 24'h0000, "unmapped read");
    $display("test order done");
  endtask
  // Aborted write, then strobe and FIFO byte
  task automatic t_abort_strobe;
    i_host.sel(1'b0);
    i_host.xfer({2'b00, 6'h11, 16'hFFFF}, 23, rx);
    i_host.sel(1'b1);
    chk({8'h00, reg_image[31:16]}, 24'h0000, "abort");
    i_host.sel(1'b0);
    i_host.xfer({2'b00, 6'h0E, 16'h0000}, 8, st);
    i_host.xfer({2'b00, 6'h3E, 16'h5A00}, 16, rx);
    fifo_rdata = 8'hC5;
    i_host.xfer({2'b01, 6'h3F, 16'h0000}, 16, fr);
    i_host.sel(1'b1);
    chk(st, 24'h0096, "strobe status");
    chk(rx, 24'h00_9600, "status after strobe");
    chk(fr, 24'h00_96C5, "fifo read");
    chk({10'h0, last_strobe, n_strobe[7:0]}, 24'h0E01, "strobe");
    chk({16'h0, last_fifo}, 24'h005A, "fifo byte");
    chk({23'h0, last_sel}, 24'h00_0001, "fifo tx select");
    $display("test abort strobe done");
  endtask
  // RAM headers are ignored; a mid-run reset clears the registers
  task automatic t_ram_reset;
    i_host.sel(1'b0);
    i_host.xfer({8'h8E, 16'h0000}, 24, rx);
    i_host.sel(1'b1);
    i_host.sel(1'b0);
    i_host.xfer({8'h90, 16'h1111}, 24, rx);
    i_host.sel(1'b1);
    chk({16'h0, n_strobe[7:0]}, 24'h00_0001, "ram not strobe");
    chk({8'h00, reg_image[15:0]}, 24'h00_A5C3, "ram not reg");
    arst_n = 1'b0;
    repeat (4) @(negedge sys_clk);
    chk({23'h0, reg_image === '0}, 24'h00_0001, "reset clears");
    arst_n = 1'b1;
    status_byte = 8'h5A;
    i_host.sel(1'b0);
    i_host.xfer({2'b00, 6'h12, 16'h0F0F}, 24, rx);
    i_host.sel(1'b1);
    chk({16'h0, rx[23:16]}, 24'h00_005A, "status after reset");
    chk({8'h00, reg_image[47:32]}, 24'h00_0F0F, "reg 0x12");
    $display("test ram reset done");
  endtask
  // Main sequence
  initial begin
    arst_n = 1'b0;
    status_byte = 8'h96;
    fifo_rdata = 8'h3C;
    mismatches = 0;
    tests_run = 0;
    n_strobe = 0;
    last_fifo = 8'h00;
    last_sel = 1'b0;
    repeat (10) @(negedge sys_clk);
    chk({23'h0, reg_image === '0}, 24'h0001, "reset image");
    arst_n = 1'b1;
    t_rw();
    t_order();
    t_abort_strobe();
    t_ram_reset();
    give_verdict();
  end
  // Watchdog
  initial begin
    #200000;
    mismatches++;
    give_verdict();
  end
endmodule
